// file: inc/aapm_pkg.sv
package aapm_pkg;
	localparam logic [7:0] A_OFFS = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_TPOS = 8'h08;
	localparam logic [7:0] A_CFG = 8'h0c;
	localparam logic [7:0] A_PPR = 8'h10;
	localparam logic [7:0] A_RMAX = 8'h14;
	localparam logic [7:0] A_MTMAX = 8'h18;
	localparam logic [7:0] A_TRAV = 8'h1c;
	localparam logic [7:0] A_GEAR = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_PERR = 8'h28;
	localparam logic [7:0] A_IRQS = 8'h2c;
	localparam logic [7:0] A_IRQC = 8'h30;
	localparam logic [7:0] A_IRQE = 8'h34;
	localparam logic [15:0] CMD_ZERO_POINT_SET_COMMAND = 16'h0009;
	localparam logic [31:0] MT1_MAX = 32'h0001869f;
	localparam logic [31:0] MT2_MIN = 32'hffff8000;
	localparam logic [31:0] MT2_MAX = 32'h00007fff;
	localparam logic [15:0] PERR_BASE = 16'h03e8;
	localparam logic [15:0] PNUM_MTMAX = 16'h0026;
	localparam logic [31:0] RST_ONE = 32'h00000001;
	localparam logic [31:0] RST_MTMAX = 32'h0000fffe;
	localparam int CFG_INF = 0;
	localparam int CFG_SIMPLE = 1;
	localparam int CFG_LATER = 2;
	localparam int CFG_PULSE = 3;
	localparam int CFG_LOAD = 4;
	localparam int CFG_SAVE = 5;
	localparam int IRQ_ZERO_POINT_SET_COMMAND = 0;
	localparam int IRQ_LINK = 1;
	localparam int IRQ_PERR = 2;
	localparam int IRQ_RANGE = 3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CAPT = 2'h1,
		ST_BUILD = 2'h3,
		ST_RUN = 2'h2
	} aapm_state_t;
endpackage

// file: hw/aapm_axis_pos.sv
`timescale 1ns/100ps
module aapm_axis_pos (
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        i_link_ok,
	input  wire logic        i_enc_valid,
	input  wire logic [31:0] i_enc_multiturn,
	input  wire logic [31:0] i_enc_init_pulses,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq,
	output logic      [31:0] o_cur_pos
);

////////////////////////////////////////////////////////////////////////////
// Drive-side inputs: two flops before use
logic [65:0] s1_q;
logic [65:0] s2_q;
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		s1_q <= '0;
		s2_q <= '0;
	end
	else
	begin
		s1_q <= {i_link_ok, i_enc_valid, i_enc_multiturn, i_enc_init_pulses};
		s2_q <= s1_q;
	end
end
wire        link_ok = s2_q[65];
wire        enc_vld = s2_q[64];
wire [31:0] mt_raw  = s2_q[63:32];
wire [31:0] init_p  = s2_q[31:0];

////////////////////////////////////////////////////////////////////////////
// Registers
aapm_pkg::aapm_state_t state_q;
logic [31:0] offs_q;
logic [15:0] cmd_q;
logic [4:0]  cfg_q;
logic [31:0] ppr_q;
logic [31:0] rmax_q;
logic [31:0] mtmax_q;
logic [31:0] trav_q;
logic [31:0] gear_q;
logic [31:0] saved_q;
logic        saved_vld_q;
logic [31:0] base_q;
logic [31:0] anchor_q;
logic        estab_q;
logic        done_q;
logic        range_q;
logic        perr_q;
logic        load_prev_q;
logic [3:0]  irq_st_q;
logic [3:0]  irq_en_q;

////////////////////////////////////////////////////////////////////////////
// APB decode
wire setup = i_psel & ~i_penable;
wire wr    = i_psel & i_penable & o_pready & i_pwrite;
wire w_offs = wr & (i_paddr == aapm_pkg::A_OFFS);
wire w_cmd  = wr & (i_paddr == aapm_pkg::A_CMD);
wire w_cfg  = wr & (i_paddr == aapm_pkg::A_CFG);
wire w_ppr  = wr & (i_paddr == aapm_pkg::A_PPR);
wire w_rmax = wr & (i_paddr == aapm_pkg::A_RMAX);
wire w_mtmx = wr & (i_paddr == aapm_pkg::A_MTMAX);
wire w_trav = wr & (i_paddr == aapm_pkg::A_TRAV);
wire w_gear = wr & (i_paddr == aapm_pkg::A_GEAR);
wire w_irqc = wr & (i_paddr == aapm_pkg::A_IRQC);
wire w_irqe = wr & (i_paddr == aapm_pkg::A_IRQE);
wire inf    = cfg_q[aapm_pkg::CFG_INF];
wire later  = cfg_q[aapm_pkg::CFG_LATER];
wire simple = inf & cfg_q[aapm_pkg::CFG_SIMPLE];
wire run    = (state_q == aapm_pkg::ST_RUN);
wire [15:0] perr_num = perr_q
	? 16'(aapm_pkg::PERR_BASE + aapm_pkg::PNUM_MTMAX) : 16'h0000;

// Zero set refused while a parameter error stands
wire zero_point_set_command = w_cmd & (i_pwdata[15:0] == aapm_pkg::CMD_ZERO_POINT_SET_COMMAND) & run
	& ~perr_q;

////////////////////////////////////////////////////////////////////////////
// Encoder position at power-up
wire [32:0] mt_mod = {1'b0, mtmax_q} + 33'h000000001;
wire [31:0] mt_eff = (inf & later)
	? 32'(({1'b0, mt_raw} % mt_mod)) : mt_raw;
wire mt_ok = later
	? (inf ? (mt_raw <= mtmax_q)
		: ($signed(mt_raw) >= $signed(aapm_pkg::MT2_MIN)
		& $signed(mt_raw) <= $signed(aapm_pkg::MT2_MAX)))
	: ($signed(mt_raw) <= $signed(aapm_pkg::MT1_MAX)
		& $signed(mt_raw) >= -$signed(aapm_pkg::MT1_MAX));
wire signed [63:0] enc_full = 64'($signed(mt_eff))
	* 64'($signed({1'b0, ppr_q}))
	+ 64'($signed(init_p));

////////////////////////////////////////////////////////////////////////////
// Reset-turns check, kept as a fraction num/den to stay exact
wire [47:0] num = cfg_q[aapm_pkg::CFG_PULSE] ? {16'h0000, rmax_q}
	: 48'(rmax_q * gear_q[15:0]);
wire [47:0] den = cfg_q[aapm_pkg::CFG_PULSE] ? {16'h0000, ppr_q}
	: 48'(trav_q * gear_q[31:16]);
wire [95:0] turns_x = 96'(mt_mod) * 96'(den);
wire [95:0] turns_rem = (num == 48'h0) ? 96'h1 : turns_x % 96'(num);
wire perr_cond = simple
	& (~later | (turns_rem != 96'h0));

////////////////////////////////////////////////////////////////////////////
// Current position
function automatic logic [31:0] wrapm(input logic [31:0] x,
	input logic [31:0] m);
	logic signed [31:0] r;
	r = $signed(x) % $signed(m);
	if (r < 0)
		r = r + $signed(m);
	return r;
endfunction
wire [31:0] sum     = base_q + offs_q;
wire [31:0] rel     = base_q - anchor_q;
wire [31:0] cur_d   = !inf ? sum
	: !estab_q ? 32'h00000000
	: simple ? wrapm(rel, rmax_q)
	: wrapm(sum, rmax_q);
wire load_rise = cfg_q[aapm_pkg::CFG_LOAD] & ~load_prev_q;

////////////////////////////////////////////////////////////////////////////
// Sequencer
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
		state_q <= aapm_pkg::ST_IDLE;
	else if (!link_ok)
		state_q <= aapm_pkg::ST_IDLE;
	else
	begin
		unique case (state_q)
			aapm_pkg::ST_IDLE:  state_q <= aapm_pkg::ST_CAPT;
			aapm_pkg::ST_CAPT:  if (enc_vld) state_q <= aapm_pkg::ST_BUILD;
			aapm_pkg::ST_BUILD: state_q <= aapm_pkg::ST_RUN;
			aapm_pkg::ST_RUN:   state_q <= aapm_pkg::ST_RUN;
		endcase
	end
end

// Capture only after the drive reports its data; host waits for run
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		base_q  <= '0;
		range_q <= 1'b0;
		perr_q  <= 1'b0;
	end
	else if (state_q == aapm_pkg::ST_CAPT && enc_vld)
		base_q <= enc_full[31:0];
	else if (state_q == aapm_pkg::ST_BUILD)
	begin
		range_q <= ~mt_ok;
		perr_q  <= perr_cond;
	end
end

// Coordinates and completion flag
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		done_q   <= 1'b0;
		estab_q  <= 1'b0;
		anchor_q <= '0;
	end
	else if (!link_ok)
	begin
		done_q  <= 1'b0;
		estab_q <= 1'b0;
	end
	else
	begin
		if (zero_point_set_command)
			done_q <= 1'b1;
		if (zero_point_set_command & simple)
		begin
			anchor_q <= base_q - offs_q;
			estab_q  <= 1'b1;
		end
		else if (run & inf & ~simple & load_rise)
			estab_q <= 1'b1;
		else if (state_q == aapm_pkg::ST_BUILD & ~inf)
			estab_q <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////
// Software registers
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		offs_q      <= '0;
		cmd_q       <= '0;
		cfg_q       <= '0;
		ppr_q       <= aapm_pkg::RST_ONE;
		rmax_q      <= aapm_pkg::RST_ONE;
		mtmax_q     <= aapm_pkg::RST_MTMAX;
		trav_q      <= aapm_pkg::RST_ONE;
		gear_q      <= {aapm_pkg::RST_ONE[15:0], aapm_pkg::RST_ONE[15:0]};
		saved_q     <= '0;
		saved_vld_q <= 1'b0;
		load_prev_q <= 1'b0;
	end
	else
	begin
		load_prev_q <= cfg_q[aapm_pkg::CFG_LOAD];
		if (state_q == aapm_pkg::ST_BUILD && saved_vld_q)
			offs_q <= saved_q;
		else if (w_offs)
			offs_q <= i_pwdata;
		if (w_cmd)
			cmd_q <= i_pwdata[15:0];
		if (w_cfg)
			cfg_q <= i_pwdata[4:0];
		if (w_cfg & i_pwdata[aapm_pkg::CFG_SAVE])
		begin
			saved_q     <= offs_q;
			saved_vld_q <= 1'b1;
		end
		if (w_ppr)
			ppr_q <= i_pwdata;
		if (w_rmax)
			rmax_q <= i_pwdata;
		if (w_mtmx)
			mtmax_q <= i_pwdata;
		if (w_trav)
			trav_q <= i_pwdata;
		if (w_gear)
			gear_q <= i_pwdata;
	end
end

////////////////////////////////////////////////////////////////////////////
// Interrupts: a new event beats a clear in the same cycle
wire [3:0] ev = {state_q == aapm_pkg::ST_BUILD & ~mt_ok,
	state_q == aapm_pkg::ST_BUILD & perr_cond,
	state_q != aapm_pkg::ST_IDLE & ~link_ok,
	zero_point_set_command};
wire [3:0] clr = w_irqc ? i_pwdata[3:0] : 4'h0;
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		irq_st_q <= '0;
		irq_en_q <= '0;
		o_irq    <= 1'b0;
	end
	else
	begin
		irq_st_q <= (irq_st_q & ~clr) | ev;
		if (w_irqe)
			irq_en_q <= i_pwdata[3:0];
		o_irq <= |(((irq_st_q & ~clr) | ev) & (w_irqe ? i_pwdata[3:0]
			: irq_en_q));
	end
end

////////////////////////////////////////////////////////////////////////////
// Read mux and bus answer; one access cycle, no wait states
wire [31:0] stat = {27'h0, estab_q, range_q, perr_q, run, done_q};
wire hit = (i_paddr <= aapm_pkg::A_IRQE) & (i_paddr[1:0] == 2'h0);
wire [31:0] rd_d =
	(i_paddr == aapm_pkg::A_OFFS)  ? offs_q :
	(i_paddr == aapm_pkg::A_CMD)   ? {16'h0, cmd_q} :
	(i_paddr == aapm_pkg::A_TPOS)  ? o_cur_pos :
	(i_paddr == aapm_pkg::A_CFG)   ? {27'h0, cfg_q} :
	(i_paddr == aapm_pkg::A_PPR)   ? ppr_q :
	(i_paddr == aapm_pkg::A_RMAX)  ? rmax_q :
	(i_paddr == aapm_pkg::A_MTMAX) ? mtmax_q :
	(i_paddr == aapm_pkg::A_TRAV)  ? trav_q :
	(i_paddr == aapm_pkg::A_GEAR)  ? gear_q :
	(i_paddr == aapm_pkg::A_STAT)  ? stat :
	(i_paddr == aapm_pkg::A_PERR)  ? {16'h0, perr_num} :
	(i_paddr == aapm_pkg::A_IRQS)  ? {28'h0, irq_st_q} :
	(i_paddr == aapm_pkg::A_IRQE)  ? {28'h0, irq_en_q} : 32'h0;
always_ff @(posedge i_sys_clk)
begin
	if (!i_nrst)
	begin
		o_pready  <= 1'b0;
		o_pslverr <= 1'b0;
		o_prdata  <= '0;
		o_cur_pos <= '0;
	end
	else
	begin
		o_pready  <= setup;
		o_pslverr <= setup & ~hit;
		if (setup)
			o_prdata <= rd_d;
		o_cur_pos <= cur_d;
	end
end

////////////////////////////////////////////////////////////////////////////
// Checks
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (!i_nrst);
sequence s_zero_point_set_command_simple;
	zero_point_set_command && simple && link_ok;
endsequence
sequence s_build_saved;
	state_q == aapm_pkg::ST_BUILD && saved_vld_q && link_ok;
endsequence
a_zero_point_set_command_done: assert property (zero_point_set_command && link_ok |=> done_q)
	else $error("zero set did not raise done");
a_link_clears: assert property (!link_ok |=> !done_q)
	else $error("done survived link loss");
a_finite_pos: assert property (!inf ##1 !inf |->
	o_cur_pos == $past(base_q) + $past(offs_q))
	else $error("finite position not base plus offset");
a_offs_shift: assert property (w_offs && !inf ##1 !inf |=>
	o_cur_pos == $past(base_q) + $past(offs_q))
	else $error("offset change not applied");
a_enc_capture: assert property (state_q == aapm_pkg::ST_CAPT
	&& enc_vld && link_ok |=> base_q == $past(enc_full[31:0]))
	else $error("encoder position mismatch");
a_range_flag: assert property (state_q == aapm_pkg::ST_BUILD
	&& !mt_ok |=> range_q)
	else $error("multiturn range not flagged");
a_perr_code: assert property (perr_q |-> perr_num == 16'h040e)
	else $error("parameter error number wrong");
a_simple_load: assert property (s_zero_point_set_command_simple ##1 (link_ok && simple)
	|=> o_cur_pos == wrapm($past(offs_q, 2), rmax_q))
	else $error("offset not loaded as position");
a_finite_keep: assert property (zero_point_set_command && !inf
	|=> $stable(anchor_q) && $stable(o_cur_pos))
	else $error("finite zero set moved coordinates");
a_reload_saved: assert property (s_build_saved
	|=> offs_q == $past(saved_q))
	else $error("saved offset not reloaded");
a_wrap_bound: assert property (inf && estab_q && rmax_q != 32'h0
	&& $stable(rmax_q) |=> o_cur_pos < $past(rmax_q))
	else $error("infinite position beyond rotary maximum");
a_full_load: assert property (run && inf && !simple && load_rise
	&& link_ok |=> estab_q)
	else $error("load bit did not establish coordinates");
endmodule

// file: sim/aapm_servo_model.sv
`timescale 1ns/100ps
module aapm_servo_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_up,
	input  wire logic [31:0] i_mt,
	input  wire logic [31:0] i_init,
	output logic             o_link_ok,
	output logic             o_enc_valid,
	output logic      [31:0] o_mt,
	output logic      [31:0] o_init
);
	logic [3:0] dly_q;
	initial
	begin
		o_link_ok = 1'b0;
		o_enc_valid = 1'b0;
		o_mt = 32'h00000000;
		o_init = 32'h00000000;
		dly_q = 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// Data lags link sync by a random span, prompt or slow
	// Idle data toggles so a stale capture cannot pass
	always @(posedge i_sys_clk)
	begin
		o_link_ok <= i_up;
		if (!i_up || dly_q != 4'h0)
		begin
			o_enc_valid <= 1'b0;
			o_mt <= ~o_mt;
			o_init <= ~o_init;
			dly_q <= i_up ? dly_q - 4'h1 : 4'($urandom_range(1, 12));
		end
		else
		begin
			o_enc_valid <= 1'b1;
			o_mt <= i_mt;
			o_init <= i_init;
		end
	end
endmodule

// file: sim/absolute_axis_position_manager_tb_top.sv
`timescale 1ns/100ps
module absolute_axis_position_manager_tb_top;
	logic        sys_clk, nrst, psel, penable, pwrite, up, lok, ev;
	logic [7:0]  paddr;
	logic [31:0] pwdata, mt, ini, emt, eini, prdata, cur_pos, rdv, e;
	logic        pready, pslverr, irq, errv;
	int          fail_count, n_tests;
	logic [31:0] ppr, off, cfg, rm, mtx, gr;
	int          k;
	aapm_servo_model u_aapm_servo_model (.i_sys_clk(sys_clk), .i_up(up),
		.i_mt(mt), .i_init(ini), .o_link_ok(lok), .o_enc_valid(ev),
		.o_mt(emt), .o_init(eini));
	aapm_axis_pos u_aapm_axis_pos (.i_sys_clk(sys_clk), .i_nrst(nrst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_link_ok(lok),
		.i_enc_valid(ev), .i_enc_multiturn(emt), .i_enc_init_pulses(eini),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_irq(irq), .o_cur_pos(cur_pos));
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_tests++;
		if (g !== x)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
			fail_count++;
		end
	endtask
	// Host waits for run-ready before touching the offset
	task automatic lnk(input logic v);
		@(posedge sys_clk);
		up <= v;
		for (int i = 0; i < 40 && v; i++)
		begin
			apb(1'b0, aapm_pkg::A_STAT, 32'h0);
			if (rdv[1] === 1'b1)
				break;
		end
		if (v)
			chk("run ready", 32'h1, 32'(rdv[1]));
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic cmd_zero_point_set_command();
		apb(1'b1, aapm_pkg::A_CMD, 32'(aapm_pkg::CMD_ZERO_POINT_SET_COMMAND));
		repeat (3) @(posedge sys_clk);
		apb(1'b0, aapm_pkg::A_STAT, 32'h0);
	endtask
	// Whole-turn test on reset turns num/den, 64 bits against overflow
	function automatic logic [31:0] exp_perr(input logic [31:0] c);
		logic [63:0] nu, de;
		nu = c[3] ? 64'(rm) : 64'(rm) * 64'(gr[15:0]);
		de = c[3] ? 64'(ppr) : 64'd360000 * 64'(gr[31:16]);
		if (c[2] && ((64'(mtx) + 64'h1) * de) % nu == 64'h0)
			return 32'h0;
		return 32'(aapm_pkg::PERR_BASE + aapm_pkg::PNUM_MTMAX);
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{nrst, psel, penable, pwrite, up} = 5'h00;
		{paddr, pwdata, mt, ini} = '0;
		{fail_count, n_tests} = '0;
		void'($urandom(76));
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		apb(1'b0, aapm_pkg::A_MTMAX, 32'h0);
		chk("mtmax reset", aapm_pkg::RST_MTMAX, rdv);
		apb(1'b0, aapm_pkg::A_GEAR, 32'h0);
		chk("gear reset", 32'h00010001, rdv);
		apb(1'b1, 8'h3c, 32'h0000ffff);
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped", 32'h00000001, {rdv[30:0], errv});
		// Finite axis build, offset shift, host zeroing
		for (k = 0; k < 3; k++)
		begin
			lnk(1'b0);
			ppr = $urandom_range(1, 4096);
			mt <= $urandom_range(0, 60000) - 30000;
			ini <= $urandom_range(0, 4095);
			off = $urandom;
			apb(1'b1, aapm_pkg::A_CFG, 32'h4);
			apb(1'b1, aapm_pkg::A_PPR, ppr);
			apb(1'b1, aapm_pkg::A_OFFS, off);
			lnk(1'b1);
			e = mt * ppr + ini + off;
			chk("pos", e, cur_pos);
			apb(1'b0, aapm_pkg::A_TPOS, 32'h0);
			chk("target pos", e, rdv);
			apb(1'b1, aapm_pkg::A_OFFS, off - e);
			repeat (3) @(posedge sys_clk);
			chk("zeroed pos", 32'h0, cur_pos);
		end
		apb(1'b1, aapm_pkg::A_IRQC, 32'hf);
		apb(1'b1, aapm_pkg::A_IRQE, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk("irq idle", 32'h0, 32'(irq));
		cmd_zero_point_set_command();
		chk("done set", 32'h1, 32'(rdv[0]));
		chk("pos kept", 32'h0, cur_pos);
		chk("irq on", 32'h1, 32'(irq));
		apb(1'b1, aapm_pkg::A_IRQC, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		lnk(1'b0);
		apb(1'b0, aapm_pkg::A_STAT, 32'h0);
		chk("done lost", 32'h0, 32'(rdv[0]));
		chk("irq link", 32'h1, 32'(irq));
		apb(1'b1, aapm_pkg::A_IRQE, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("irq masked", 32'h0, 32'(irq));
		apb(1'b1, aapm_pkg::A_IRQC, 32'hf);
		// Multiturn upper limit of the MT1 and MT2 families, just inside and just outside
		for (k = 0; k < 4; k++)
		begin
			mt <= k[0] ? (k[1] ? 32'd100000 : 32'd32768)
				: (k[1] ? 32'd99999 : 32'd32767);
			apb(1'b1, aapm_pkg::A_CFG, k[1] ? 32'h0 : 32'h4);
			lnk(1'b1);
			apb(1'b0, aapm_pkg::A_STAT, 32'h0);
			chk("range", 32'(k[0]), 32'(rdv[3]));
			lnk(1'b0);
		end
		// Simple infinite: whole-turn check, zero set anchoring
		for (k = 0; k < 5; k++)
		begin
			cfg = k == 4 ? 32'hb : (k < 2 ? 32'hf : 32'h7);
			ppr = k < 2 || k == 4 ? 32'd100 : 32'd16384;
			rm = k < 2 || k == 4 ? (k == 1 ? 32'd200 : 32'd300)
				: 32'd360000;
			mtx = k < 2 || k == 4 ? 32'd65534 : 32'd59705 - 32'(k - 2);
			gr = 32'h00050006;
			mt <= $urandom_range(0, mtx);
			ini <= 32'h0;
			apb(1'b1, aapm_pkg::A_CFG, cfg);
			apb(1'b1, aapm_pkg::A_PPR, ppr);
			apb(1'b1, aapm_pkg::A_RMAX, rm);
			apb(1'b1, aapm_pkg::A_MTMAX, mtx);
			apb(1'b1, aapm_pkg::A_TRAV, 32'd360000);
			apb(1'b1, aapm_pkg::A_GEAR, gr);
			lnk(1'b1);
			apb(1'b0, aapm_pkg::A_PERR, 32'h0);
			e = exp_perr(cfg);
			chk("perr num", e, rdv);
			if (e == 32'h0)
			begin
				off = $urandom_range(0, 2 * rm);
				apb(1'b1, aapm_pkg::A_OFFS, off);
				cmd_zero_point_set_command();
				chk("anchor", off % rm, cur_pos);
			end
			lnk(1'b0);
		end
		// Full infinite: nothing until load bit, multiturn wrapped
		apb(1'b1, aapm_pkg::A_CFG, 32'h5);
		apb(1'b1, aapm_pkg::A_PPR, 32'h1);
		apb(1'b1, aapm_pkg::A_RMAX, 32'd1000);
		apb(1'b1, aapm_pkg::A_MTMAX, 32'd9);
		apb(1'b1, aapm_pkg::A_OFFS, 32'h0);
		mt <= 32'd23;
		lnk(1'b1);
		chk("pos unset", 32'h0, cur_pos);
		apb(1'b1, aapm_pkg::A_CFG, 32'h15);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, aapm_pkg::A_STAT, 32'h0);
		chk("established", 32'h1, 32'(rdv[4]));
		chk("mt wrapped", 32'd3, cur_pos);
		// Saved offset comes back after a link restart
		off = $urandom;
		apb(1'b1, aapm_pkg::A_CFG, 32'h4);
		apb(1'b1, aapm_pkg::A_OFFS, off);
		apb(1'b1, aapm_pkg::A_CFG, 32'h24);
		apb(1'b1, aapm_pkg::A_OFFS, ~off);
		lnk(1'b0);
		lnk(1'b1);
		apb(1'b0, aapm_pkg::A_OFFS, 32'h0);
		chk("reloaded", off, rdv);
		report_and_stop();
	end
endmodule
